// *** rtl/cbsc_pkg.sv ***
// shared constants for the charge bank state controller
package cbsc_pkg;
  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 100_000_000; // system clock rate
  localparam int unsigned TICK_SEC    = 1;           // tick period in seconds
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_SEC;

  // ---------------------------------------------------------------
  // regulator states
  // ---------------------------------------------------------------
  localparam int unsigned NUM_STATES = 9;            // states 0..8
  localparam logic [3:0]  ST_FIRST   = 4'h0;         // reset state, all on
  localparam logic [3:0]  ST_BOOST_LAST = 4'h3;      // boost is 0..3
  localparam logic [3:0]  ST_ALL_OFF = 4'h4;         // first float state
  localparam logic [3:0]  ST_LAST    = 4'h8;         // top float state

  // bank masks, bit 3 = bank d ... bit 0 = bank a
  localparam logic [3:0]  MASK_ALL   = 4'hf;
  localparam logic [3:0]  MASK_NONE  = 4'h0;

  // ---------------------------------------------------------------
  // settings and alarms
  // ---------------------------------------------------------------
  localparam logic [7:0]  DELAY_RST  = 8'h0a;        // boost delay, seconds
  localparam int unsigned ALARM_NUM  = 7;            // alarm inputs
  localparam logic [7:0]  ALARM_RST  = 8'h00;
endpackage

// *** rtl/cbsc_tick_gen.sv ***
// one-second tick generator
`timescale 1ns/10ps
`default_nettype none
module cbsc_tick_gen #(
  parameter int unsigned TICK_CYCLES = cbsc_pkg::TICK_CYCLES
) (
  input  wire logic      clock,
  input  wire logic      sys_rst,
  cbsc_tick_if.source    tick_port
);
  // ---------------------------------------------------------------
  // cycle counter
  // ---------------------------------------------------------------
  logic [31:0] cnt_reg;  // cycles into the current second
  logic [31:0] cnt_next;
  logic        tick_reg; // registered pulse
  logic        tick_next;

  // wrap at the period, pulse on the wrap
  always_comb begin
    if (cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      cnt_next  = 32'h0;
      tick_next = 1'b1;
    end else begin
      cnt_next  = cnt_reg + 32'h1;
      tick_next = 1'b0;
    end
  end

  // register only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_port.tick = tick_reg;
endmodule
`default_nettype wire

// *** rtl/cbsc_tick_if.sv ***
// one-second tick carried from the tick generator to the controller
`timescale 1ns/10ps
`default_nettype none
interface cbsc_tick_if;
  logic tick; // one-cycle pulse each second

  modport source (output tick);
  modport sink   (input tick);
endinterface
`default_nettype wire

// *** rtl/cbsc_top.sv ***
// charge bank state controller with hardware exercise mode
`timescale 1ns/10ps
`default_nettype none
module cbsc_top #(
  parameter int unsigned TICK_CYCLES = cbsc_pkg::TICK_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic       volt_above,      // battery above the state's upper level
  input  wire logic       volt_below,      // battery below the state's lower level
  input  wire logic [7:0] delay_sec_in,    // boost delay to load, seconds
  input  wire logic       delay_sec_wr,    // load pulse for the delay setting
  input  wire logic       calibrate_key,   // key press pulses
  input  wire logic       increment_key,
  input  wire logic       decrement_key,
  input  wire logic       nv_check_done,   // nonvolatile check finished
  input  wire logic       serial_done,     // serial burst finished
  input  wire logic [6:0] alarm_in,        // alarm inputs, 1 = active
  output logic      [3:0] bank_on,         // bank d..a switch drives
  output logic      [3:0] reg_state,       // current regulator state
  output logic            float_mode,      // states 4..8
  output logic            exercise_active,
  output logic            exercise_paused,
  output logic            charge_on,
  output logic            load_on,
  output logic            nv_check_req,    // level until done
  output logic            serial_req,      // level until done
  output logic      [7:0] alarm_status,
  output logic      [7:0] delay_sec
);
  // ---------------------------------------------------------------
  // types and helpers
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CBSC_SEQ_IDLE = 4'b0001,
    CBSC_SEQ_CAL  = 4'b0010,
    CBSC_SEQ_INC1 = 4'b0100,
    CBSC_SEQ_INC2 = 4'b1000
  } cbsc_seq_type;

  typedef enum logic [5:0] {
    CBSC_EX_OFF   = 6'b000001,
    CBSC_EX_CHG   = 6'b000010,
    CBSC_EX_LOAD  = 6'b000100,
    CBSC_EX_NV    = 6'b001000,
    CBSC_EX_CYCLE = 6'b010000,
    CBSC_EX_SER   = 6'b100000
  } cbsc_ex_type;

  // bank mask per state; float states above 4 re-add banks a upward
  function automatic logic [3:0] bank_mask(input logic [3:0] st);
    logic [3:0] m;
    m = cbsc_pkg::MASK_NONE;
    if (st <= cbsc_pkg::ST_ALL_OFF)
      m = 4'(cbsc_pkg::MASK_ALL >> st);
    else
      m = 4'(cbsc_pkg::MASK_ALL >> (cbsc_pkg::ST_LAST - st));
    return m;
  endfunction

  // voltage step: above steps up (fewer banks in boost, more in float), below steps down
  function automatic logic [3:0] step_state(input logic [3:0] st,
                                            input logic up, input logic dn);
    logic [3:0] n;
    n = st;
    if (up && st < cbsc_pkg::ST_LAST)
      n = st + 4'h1;
    else if (dn && st > cbsc_pkg::ST_FIRST)
      n = st - 4'h1;
    return n;
  endfunction

  // ---------------------------------------------------------------
  // tick source
  // ---------------------------------------------------------------
  cbsc_tick_if tick_bus ();

  cbsc_tick_gen #(
    .TICK_CYCLES (TICK_CYCLES)
  ) cbsc_tick_gen_i (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .tick_port (tick_bus.source)
  );

  wire logic tick = tick_bus.tick; // shared one-second pulse

  // ---------------------------------------------------------------
  // state registers
  // ---------------------------------------------------------------
  logic [3:0]   state_reg,  state_next;
  logic [7:0]   secs_reg,   secs_next;   // seconds spent waiting in boost
  logic [7:0]   delay_reg,  delay_next;  // settings: boost delay
  cbsc_seq_type seq_reg,    seq_next;    // entry key sequence
  cbsc_ex_type  ex_reg,     ex_next;     // exercise phase
  logic         pause_reg,  pause_next;
  logic         chg_reg,    chg_next;
  logic         load_reg,   load_next;
  logic [3:0]   bank_reg,   bank_next;
  logic [7:0]   alarm_reg,  alarm_next;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    secs_next  = secs_reg;
    delay_next = delay_reg;
    seq_next   = seq_reg;
    ex_next    = ex_reg;
    pause_next = pause_reg;
    chg_next   = chg_reg;
    load_next  = load_reg;
    alarm_next = {1'b0, alarm_in};

    // settings write; zero would behave like one in boost, and it is stored as one second
    if (delay_sec_wr)
      delay_next = (delay_sec_in == 8'h00) ? 8'h01 : delay_sec_in;

    case (ex_reg)
      CBSC_EX_OFF: begin
        // normal regulation
        chg_next  = 1'b1;
        load_next = 1'b1;
        if (tick) begin
          if (state_reg <= cbsc_pkg::ST_BOOST_LAST) begin
            // boost: wait the delay before acting
            if (secs_reg + 8'h01 >= delay_reg) begin
              state_next = step_state(state_reg, volt_above, volt_below);
              secs_next  = 8'h00;
            end else begin
              secs_next = secs_reg + 8'h01;
            end
          end else begin
            state_next = step_state(state_reg, volt_above, volt_below);
            secs_next  = 8'h00;
          end
        end
        // entry key sequence is the operator's job; the closing calibrate press starts exercise mode
        case (seq_reg)
          CBSC_SEQ_IDLE: begin
            if (calibrate_key) seq_next = CBSC_SEQ_CAL;
          end
          CBSC_SEQ_CAL: begin
            if (increment_key) seq_next = CBSC_SEQ_INC1;
            else if (decrement_key) seq_next = CBSC_SEQ_IDLE;
          end
          CBSC_SEQ_INC1: begin
            if (increment_key) seq_next = CBSC_SEQ_INC2;
            else if (calibrate_key || decrement_key) seq_next = CBSC_SEQ_IDLE;
          end
          CBSC_SEQ_INC2: begin
            if (calibrate_key) begin
              seq_next   = CBSC_SEQ_IDLE;
              ex_next    = CBSC_EX_CHG;
              pause_next = 1'b0;
              chg_next   = 1'b0;
              load_next  = 1'b0;
            end else if (increment_key || decrement_key) begin
              seq_next = CBSC_SEQ_IDLE;
            end
          end
          default: seq_next = CBSC_SEQ_IDLE;
        endcase
      end
      default: begin
        // exercise mode; charge and load steps last one tick unless paused, the cycle step walks states 0..8 one per tick, nv and serial steps last until done
        if (increment_key)
          pause_next = ~pause_reg;
        if (tick && !pause_reg) begin
          case (ex_reg)
            CBSC_EX_CHG: begin
              chg_next = 1'b1;
              ex_next  = CBSC_EX_LOAD;
            end
            CBSC_EX_LOAD: begin
              load_next = 1'b1;
              ex_next   = CBSC_EX_NV;
            end
            CBSC_EX_NV: begin
              if (nv_check_done) begin
                ex_next    = CBSC_EX_CYCLE;
                state_next = cbsc_pkg::ST_FIRST;
              end
            end
            CBSC_EX_CYCLE: begin
              if (state_reg == cbsc_pkg::ST_LAST)
                ex_next = CBSC_EX_SER;
              else
                state_next = state_reg + 4'h1;
            end
            CBSC_EX_SER: begin
              if (serial_done) begin
                ex_next   = CBSC_EX_CHG; // repeat
                chg_next  = 1'b0;
                load_next = 1'b0;
              end
            end
            default: ex_next = CBSC_EX_OFF;
          endcase
        end
        // termination outranks everything else in the same cycle
        if (decrement_key) begin
          ex_next    = CBSC_EX_OFF;
          pause_next = 1'b0;
          state_next = cbsc_pkg::ST_FIRST;
          secs_next  = 8'h00;
          chg_next   = 1'b1;
          load_next  = 1'b1;
        end
      end
    endcase
    bank_next = bank_mask(state_next);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= cbsc_pkg::ST_FIRST;
      secs_reg  <= 8'h00;
      delay_reg <= cbsc_pkg::DELAY_RST;
      seq_reg   <= CBSC_SEQ_IDLE;
      ex_reg    <= CBSC_EX_OFF;
      pause_reg <= 1'b0;
      chg_reg   <= 1'b1;
      load_reg  <= 1'b1;
      bank_reg  <= cbsc_pkg::MASK_ALL;
      alarm_reg <= cbsc_pkg::ALARM_RST;
    end else begin
      state_reg <= state_next;
      secs_reg  <= secs_next;
      delay_reg <= delay_next;
      seq_reg   <= seq_next;
      ex_reg    <= ex_next;
      pause_reg <= pause_next;
      chg_reg   <= chg_next;
      load_reg  <= load_next;
      bank_reg  <= bank_next;
      alarm_reg <= alarm_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  logic float_reg;   // mirrors state_next range
  logic nvreq_reg;
  logic serreq_reg;
  logic active_reg;  // exercise running; a flop so the port never glitches on decode

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      float_reg  <= 1'b0;
      nvreq_reg  <= 1'b0;
      serreq_reg <= 1'b0;
      active_reg <= 1'b0;
    end else begin
      float_reg  <= (state_next > cbsc_pkg::ST_BOOST_LAST);
      nvreq_reg  <= (ex_next == CBSC_EX_NV);
      serreq_reg <= (ex_next == CBSC_EX_SER);
      active_reg <= (ex_next != CBSC_EX_OFF);
    end
  end

  assign bank_on         = bank_reg;
  assign reg_state       = state_reg;
  assign float_mode      = float_reg;
  assign exercise_active = active_reg;
  assign exercise_paused = pause_reg;
  assign charge_on       = chg_reg;
  assign load_on         = load_reg;
  assign nv_check_req    = nvreq_reg;
  assign serial_req      = serreq_reg;
  assign alarm_status    = alarm_reg;
  assign delay_sec       = delay_reg;
endmodule
`default_nettype wire

// *** sim/cbsc_batt_model.sv ***
// battery level comparator model facing the controller
`timescale 1ns/10ps
`default_nettype none
module cbsc_batt_model (
  input  wire logic       clock,
  input  wire logic [1:0] trend,      // 1 rising, 2 sagging, 0 steady
  output logic            volt_above,
  output logic            volt_below
);
  // comparators lag the battery by a cycle, as a real sense path would
  always_ff @(posedge clock) begin
    volt_above <= trend == 2'h1;
    volt_below <= trend == 2'h2;
  end
endmodule
`default_nettype wire

// *** sim/cbsc_top_properties.sv ***
// assertions on the controller ports
`timescale 1ns/10ps
`default_nettype none
module cbsc_top_properties #(
  parameter int unsigned TICK_CYCLES = cbsc_pkg::TICK_CYCLES
) (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       increment_key,
  input wire logic       decrement_key,
  input wire logic [7:0] delay_sec_in,
  input wire logic       delay_sec_wr,
  input wire logic [6:0] alarm_in,
  input wire logic [3:0] bank_on,
  input wire logic [3:0] reg_state,
  input wire logic       float_mode,
  input wire logic       exercise_active,
  input wire logic       exercise_paused,
  input wire logic       charge_on,
  input wire logic       load_on,
  input wire logic [7:0] alarm_status,
  input wire logic [7:0] delay_sec
);
  // ----------------------------------------
  // move spacing helper
  // ----------------------------------------
  logic [3:0]  prev_reg, prev_next;  // state one cycle back
  logic [15:0] gap_reg, gap_next;    // cycles since last move
  // restart on every move so float spacing can be judged
  always_comb begin
    prev_next = reg_state;
    gap_next  = (reg_state != prev_reg || sys_rst) ? 16'h0 : gap_reg + 16'h1;
  end
  always_ff @(posedge clock) begin
    prev_reg <= prev_next;
    gap_reg  <= gap_next;
  end
  // banks per state, d dropped first on the way up
  function automatic logic [3:0] mask_of(input logic [3:0] s);
    case (s)
      4'h0, 4'h8: mask_of = 4'hf;
      4'h1, 4'h7: mask_of = 4'h7;
      4'h2, 4'h6: mask_of = 4'h3;
      4'h3, 4'h5: mask_of = 4'h1;
      default:    mask_of = 4'h0;
    endcase
  endfunction
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  AST_RESET_STATE: assert property ($past(sys_rst) |-> reg_state == 4'h0 && bank_on == 4'hf)
    else $error("reset state wrong");
  AST_ALARM_PACK: assert property (!$past(sys_rst) |-> alarm_status == {1'b0, $past(alarm_in)})
    else $error("alarm byte wrong");
  AST_BANK_MASK: assert property (!exercise_active |-> bank_on == mask_of(reg_state))
    else $error("bank mask wrong");
  AST_FLOAT_FLAG: assert property (float_mode == (reg_state >= 4'h4))
    else $error("float flag wrong");
  AST_STATE_RANGE: assert property (reg_state <= 4'h8)
    else $error("state out of range");
  AST_ONE_STEP: assert property (!$stable(reg_state) && !exercise_active && !$past(exercise_active)
    && !$past(sys_rst) |-> reg_state == $past(reg_state) + 4'h1 || reg_state == $past(reg_state) - 4'h1)
    else $error("state jumped");
  AST_FLOAT_TICK: assert property (!$stable(reg_state) && float_mode && $past(float_mode)
    && !exercise_active && !$past(exercise_active) |-> (gap_reg + 16'h1) % TICK_CYCLES == 0)
    else $error("float move off tick");
  AST_EXIT: assert property (decrement_key && exercise_active |=> !exercise_active
    && !exercise_paused && reg_state == 4'h0 && bank_on == 4'hf && charge_on && load_on)
    else $error("exit wrong");
  AST_PAUSE_FLIP: assert property (increment_key && exercise_active && !decrement_key
    |=> exercise_paused != $past(exercise_paused))
    else $error("pause not toggled");
  AST_PAUSE_HOLD: assert property (exercise_active && exercise_paused && !increment_key
    && !decrement_key |=> $stable(reg_state) && $stable(charge_on) && $stable(load_on))
    else $error("moved while paused");
  AST_DELAY_WR: assert property (delay_sec_wr |=> delay_sec
    == (($past(delay_sec_in) == 8'h0) ? 8'h1 : $past(delay_sec_in)))
    else $error("delay not stored");
endmodule
bind cbsc_top cbsc_top_properties #(.TICK_CYCLES(TICK_CYCLES)) cbsc_top_properties_i (
  .clock(clock), .sys_rst(sys_rst), .increment_key(increment_key), .decrement_key(decrement_key),
  .delay_sec_in(delay_sec_in), .delay_sec_wr(delay_sec_wr), .alarm_in(alarm_in), .bank_on(bank_on),
  .reg_state(reg_state), .float_mode(float_mode), .exercise_active(exercise_active),
  .exercise_paused(exercise_paused), .charge_on(charge_on), .load_on(load_on),
  .alarm_status(alarm_status), .delay_sec(delay_sec));
`default_nettype wire

// *** sim/test_charge_bank_state_controller.sv ***
// self-checking bench for the charge bank state controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(name, exp, got) \
  begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", name, exp, got); end end
module test_charge_bank_state_controller;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam int T = 20;  // short tick keeps the run brief
  localparam logic [3:0] MASKS [9] = '{4'hf, 4'h7, 4'h3, 4'h1, 4'h0, 4'h1, 4'h3, 4'h7, 4'hf};
  logic clock, sys_rst, volt_above, volt_below, delay_sec_wr;
  logic calibrate_key, increment_key, decrement_key, nv_check_done, serial_done;
  logic charge_on, load_on, nv_check_req, serial_req, float_mode;
  logic exercise_active, exercise_paused;
  logic [1:0] trend;
  logic [3:0] bank_on, reg_state;
  logic [6:0] alarm_in;
  logic [7:0] delay_sec_in, alarm_status, delay_sec;
  int fail_count, total_checks, n;
  cbsc_top #(.TICK_CYCLES(T)) cbsc_top_i (.clock(clock), .sys_rst(sys_rst), .volt_above(volt_above),
    .volt_below(volt_below), .delay_sec_in(delay_sec_in), .delay_sec_wr(delay_sec_wr),
    .calibrate_key(calibrate_key), .increment_key(increment_key), .decrement_key(decrement_key),
    .nv_check_done(nv_check_done), .serial_done(serial_done), .alarm_in(alarm_in), .bank_on(bank_on),
    .reg_state(reg_state), .float_mode(float_mode), .exercise_active(exercise_active),
    .exercise_paused(exercise_paused), .charge_on(charge_on), .load_on(load_on),
    .nv_check_req(nv_check_req), .serial_req(serial_req), .alarm_status(alarm_status),
    .delay_sec(delay_sec));
  cbsc_batt_model cbsc_batt_model_i (.clock(clock), .trend(trend), .volt_above(volt_above),
    .volt_below(volt_below));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
  endtask
  // one-cycle key pulse: 0 calibrate, 1 increment, 2 decrement
  task automatic press(input int k);
    @(posedge clock);
    calibrate_key <= k == 0;
    increment_key <= k == 1;
    decrement_key <= k == 2;
    @(posedge clock);
    {calibrate_key, increment_key, decrement_key} <= 3'h0;
    #1;
  endtask
  // bounded wait for a state, n gives the cycles spent
  task automatic wait_state(input logic [3:0] s);
    n = 0;
    while (reg_state !== s) begin
      @(posedge clock);
      #1;
      n++;
      if (n > 400) begin fail_count++; final_report(); end
    end
  endtask
  // bounded wait for a flag: 0 charge, 1 load, 2 nv request, 3 serial request
  task automatic wait_hi(input int w);
    for (int i = 0; i < 400; i++) begin
      if ((w == 0 ? charge_on : w == 1 ? load_on : w == 2 ? nv_check_req : serial_req) === 1'b1) return;
      @(posedge clock);
      #1;
    end
    fail_count++;
    final_report();
  endtask
  task automatic t_reset();
    `CHK("state", 4'h0, reg_state)
    `CHK("banks", 4'hf, bank_on)
    `CHK("delay", 8'h0a, delay_sec)
    `CHK("float", 1'b0, float_mode)
  endtask
  task automatic t_alarm();
    for (int i = 0; i < 8; i++) begin
      @(posedge clock);
      alarm_in <= (i == 7) ? 7'h7f : 7'h01 << i;
      @(posedge clock);
      #1;
      `CHK("alarm", {1'b0, alarm_in}, alarm_status)
    end
  endtask
  task automatic wr_delay(input logic [7:0] v, input logic [7:0] e);
    @(posedge clock);
    delay_sec_in <= v;
    delay_sec_wr <= 1'b1;
    @(posedge clock);
    delay_sec_wr <= 1'b0;
    #1;
    `CHK("delay", e, delay_sec)
  endtask
  // up through boost into float, then back down; boost waits two seconds
  task automatic t_climb();
    trend <= 2'h1;
    for (int s = 1; s < 9; s++) begin
      wait_state(s[3:0]);
      if (s > 1) `CHK("gap", (s <= 4 ? 2 : 1) * T, n)
      `CHK("banks", MASKS[s], bank_on)
      `CHK("float", s >= 4, float_mode)
    end
    repeat (3 * T) @(posedge clock);
    #1;
    `CHK("top", 4'h8, reg_state)
    trend <= 2'h2;
    for (int s = 7; s > 3; s--) begin
      wait_state(s[3:0]);
      if (s < 7) `CHK("gap", T, n)
    end
    trend <= 2'h0;
    repeat (3 * T) @(posedge clock);
    #1;
    `CHK("steady", 4'h4, reg_state)
  endtask
  task automatic t_exercise();
    int keys [9] = '{0, 1, 2, 1, 0, 0, 1, 1, 0};
    do_reset();
    trend <= 2'h1;
    for (int i = 0; i < 9; i++) begin
      press(keys[i]);
      if (i == 4) `CHK("entry", 1'b0, exercise_active)
    end
    `CHK("active", 1'b1, exercise_active)
    `CHK("charge", 1'b0, charge_on)
    `CHK("load", 1'b0, load_on)
    wait_hi(0);
    `CHK("load", 1'b0, load_on)
    `CHK("nvreq", 1'b0, nv_check_req)
    wait_hi(1);
    wait_hi(2);
    `CHK("serreq", 1'b0, serial_req)
    `CHK("charge", 1'b1, charge_on)
    @(posedge clock);
    nv_check_done <= 1'b1;
    for (int s = 1; s < 9; s++) begin
      wait_state(s[3:0]);
      if (s > 1 && s != 5) `CHK("cycle", T, n)
      if (s == 4) begin
        press(1);
        `CHK("paused", 1'b1, exercise_paused)
        repeat (3 * T) @(posedge clock);
        #1;
        `CHK("held", 4'h4, reg_state)
        press(1);
        `CHK("resumed", 1'b0, exercise_paused)
      end
    end
    wait_hi(3);
    `CHK("cycend", 4'h8, reg_state)
    `CHK("nvreq", 1'b0, nv_check_req)
    @(posedge clock);
    serial_done <= 1'b1;
    wait_hi(2);
    press(2);
    `CHK("exit", 1'b0, exercise_active)
    `CHK("state", 4'h0, reg_state)
    `CHK("banks", 4'hf, bank_on)
    `CHK("charge", 1'b1, charge_on)
    `CHK("load", 1'b1, load_on)
    `CHK("nvreq", 1'b0, nv_check_req)
    `CHK("serreq", 1'b0, serial_req)
  endtask
  initial begin
    {sys_rst, delay_sec_wr, calibrate_key, increment_key, decrement_key} = 5'h10;
    {nv_check_done, serial_done, trend, alarm_in, delay_sec_in} = 'h0;
    fail_count = 0;
    total_checks = 0;
    do_reset();
    t_reset();
    t_alarm();
    wr_delay(8'h00, 8'h01);
    wr_delay(8'h02, 8'h02);
    t_climb();
    t_exercise();
    final_report();
  end
endmodule
`default_nettype wire
